// file: rtl/gcr_pkg.sv
// constants and types of the gauge command map
package gcr_pkg;

  // ------------------------------------------------------------------
  // bus addressing
  // ------------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h55; // bus address, arbitrary value
  localparam int NUM_STD = 23;
  localparam int NUM_WORDS = 32;
  localparam int FLASH_BYTES = 32;
  localparam logic [2:0] FLASH_PAGE = 3'h2; // codes 0x40..0x5f

  // ------------------------------------------------------------------
  // standard word command codes (low byte at the even code)
  // ------------------------------------------------------------------
  localparam logic [7:0] STD_CODES [NUM_STD] = '{
    8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e,
    8'h10, 8'h12, 8'h14, 8'h16, 8'h1a, 8'h1c, 8'h22, 8'h24,
    8'h26, 8'h28, 8'h2a, 8'h2c, 8'h30, 8'h36, 8'h3a};
  localparam int IX_CONTROL = 0;
  localparam int IX_AT_RATE = 1;
  localparam int IX_TEMPERATURE = 3;
  localparam int IX_CHARGE = 19;
  localparam int IX_OPERATION_CONFIG = 22;

  // ------------------------------------------------------------------
  // control subcommands and identity words
  // ------------------------------------------------------------------
  localparam logic [15:0] SUB_STATUS = 16'h0000;
  localparam logic [15:0] SUB_DEV_TYPE = 16'h0001;
  localparam logic [15:0] SUB_FW_VER = 16'h0002;
  localparam logic [15:0] SUB_SET_HIB = 16'h0011;
  localparam logic [15:0] SUB_CLR_HIB = 16'h0012;
  localparam logic [15:0] SUB_SET_SNOOZE = 16'h0013;
  localparam logic [15:0] SUB_CLR_SNOOZE = 16'h0014;
  localparam logic [15:0] SUB_LOCK = 16'h0020;
  localparam logic [15:0] DEV_TYPE_CODE = 16'h1234; // arbitrary value
  localparam logic [15:0] FW_VER_CODE = 16'h0100; // arbitrary value
  localparam logic [15:0] OPEN_KEY1 = 16'h1111; // arbitrary value
  localparam logic [15:0] OPEN_KEY2 = 16'h2222; // arbitrary value

  // ------------------------------------------------------------------
  // status word fields, configuration fields, reset values
  // ------------------------------------------------------------------
  localparam int STS_LOCKED = 13;
  localparam int STS_HIB = 6;
  localparam int STS_SNOOZE = 5;
  localparam int STS_SLEEP = 4;
  localparam int CFG_HOST_TEMP = 0;
  localparam logic [15:0] OPERATION_CONFIG_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic LOCKED_RESET = 1'b0;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_NS = 4;
  localparam int SOC_INT_NS = 1000;
  localparam logic [15:0] SOC_INT_CYCLES = 16'(SOC_INT_NS / CLK_NS);

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    PM_INSERT_CHECK, PM_NORMAL, PM_ENH_SLEEP, PM_SLEEP, PM_HIBERNATE
  } gcr_pmode_t;

  typedef enum logic [2:0] {
    TS_IDLE, TS_ADDR, TS_ACK, TS_WDATA, TS_RDATA, TS_RACK
  } gcr_tstate_t;

endpackage : gcr_pkg

// file: rtl/gcr_link_if.sv
// byte level link between serial target engine and register map
`timescale 1ns/10ps
interface gcr_link_if;
  logic addr_seen;
  logic wr_valid;
  logic wr_first;
  logic [7:0] wr_data;
  logic rd_next;
  logic [7:0] rd_data;
  logic accept;

  modport engine (
    output addr_seen, wr_valid, wr_first, wr_data, rd_next,
    input rd_data, accept
  );
  modport regs (
    input addr_seen, wr_valid, wr_first, wr_data, rd_next,
    output rd_data, accept
  );
endinterface : gcr_link_if

// file: rtl/gcr_i2c_target.sv
// serial bus target engine: start, stop, address, byte transfer
`timescale 1ns/10ps
module gcr_i2c_target
  import gcr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // register side
  gcr_link_if.engine lk
);

  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  gcr_tstate_t st, next_st;
  logic [3:0] bcnt, next_bcnt;
  logic [7:0] shreg, next_shreg;
  logic is_rd, next_is_rd, first, next_first, next_oe;
  logic next_addr_seen, next_wr_valid, next_wr_first, next_rd_next;
  logic [7:0] next_wr_data;

  // ------------------------------------------------------------------
  // pin synchronisers and edge detection
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;
  assign sda_o = 1'b0; // open drain: only ever pulls low

  // ------------------------------------------------------------------
  // transfer sequencer
  // ------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_bcnt = bcnt;
    next_shreg = shreg;
    next_is_rd = is_rd;
    next_first = first;
    next_oe = sda_oe;
    next_addr_seen = 1'b0;
    next_wr_valid = 1'b0;
    next_wr_first = lk.wr_first;
    next_wr_data = lk.wr_data;
    next_rd_next = 1'b0;
    if (bus_start) begin
      next_st = TS_ADDR;
      next_bcnt = 4'h0;
      next_oe = 1'b0;
      next_first = 1'b1;
    end else if (bus_stop) begin
      next_st = TS_IDLE;
      next_oe = 1'b0;
    end else begin
      case (st)
        TS_ADDR: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s};
            next_bcnt = bcnt + 4'h1;
          end else if (scl_fall && bcnt == 4'h8) begin
            next_bcnt = 4'h0;
            next_st = TS_IDLE;
            // R12 answer only our own address
            if (shreg[7:1] == DEV_ADDR) begin
              next_addr_seen = 1'b1;
              // R3 not answering while asleep too deeply
              if (lk.accept) begin
                next_is_rd = shreg[0];
                next_oe = 1'b1;
                next_st = TS_ACK;
              end
            end
          end
        end
        TS_ACK: begin
          if (scl_fall) begin
            if (is_rd) begin
              next_shreg = lk.rd_data;
              next_oe = ~lk.rd_data[7];
              next_rd_next = 1'b1;
              next_bcnt = 4'h1;
              next_st = TS_RDATA;
            end else begin
              next_oe = 1'b0;
              next_bcnt = 4'h0;
              next_st = TS_WDATA;
            end
          end
        end
        TS_WDATA: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s};
            next_bcnt = bcnt + 4'h1;
          end else if (scl_fall && bcnt == 4'h8) begin
            next_wr_valid = 1'b1;
            next_wr_data = shreg;
            next_wr_first = first;
            next_first = 1'b0;
            next_oe = 1'b1;
            next_st = TS_ACK;
          end
        end
        TS_RDATA: begin
          if (scl_fall) begin
            if (bcnt == 4'h8) begin
              next_oe = 1'b0;
              next_st = TS_RACK;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_oe = ~shreg[6];
              next_bcnt = bcnt + 4'h1;
            end
          end
        end
        TS_RACK: begin
          if (scl_rise) begin
            next_st = sda_s ? TS_IDLE : TS_ACK; // nack ends the read
          end
        end
        default: next_st = TS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= TS_IDLE;
      bcnt <= 4'h0;
      shreg <= 8'h00;
      is_rd <= 1'b0;
      first <= 1'b0;
      sda_oe <= 1'b0;
      lk.addr_seen <= 1'b0;
      lk.wr_valid <= 1'b0;
      lk.wr_first <= 1'b0;
      lk.wr_data <= 8'h00;
      lk.rd_next <= 1'b0;
    end else begin
      st <= next_st;
      bcnt <= next_bcnt;
      shreg <= next_shreg;
      is_rd <= next_is_rd;
      first <= next_first;
      sda_oe <= next_oe;
      lk.addr_seen <= next_addr_seen;
      lk.wr_valid <= next_wr_valid;
      lk.wr_first <= next_wr_first;
      lk.wr_data <= next_wr_data;
      lk.rd_next <= next_rd_next;
    end
  end

endmodule : gcr_i2c_target

// file: rtl/gcr_command_map.sv
// gauge standard command map with power modes and access control
//
// Functional notes
// R1: each battery quantity is one 16-bit word at a pair of byte codes.
// R2: the host sends the command code first, then reads or writes data.
// R3: standard commands are taken and answered in normal operation.
// R4: when locked, only control, rate and temperature words take writes.
// R5: the host leaves the bus idle for the minimum time after a stop.
// R6: five power modes, entered on events or on host request.
// R7: with host temperature selected, the host word is the temperature.
// R8: the host reaches flash data by subclass and offset sequences; here one 32-byte block is mapped directly at codes 0x40..0x5f.
// R9: a 32-byte user block of manufacturer data is held in the device.
// R10: the flash block is refused while the device is locked.
// R11: a charge-level interrupt output is driven to the host.
// R12: the host starts every transfer; the device only answers.
// R13: a control word write carries a 16-bit subcommand.
// R14: the low byte sits at the even code, the high byte at the odd.
`timescale 1ns/10ps
module gcr_command_map
  import gcr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // measured words from the gauge core, indexed by code / 2
  input wire logic [NUM_WORDS-1:0][15:0] core_word,
  // gauge core events
  input wire logic batt_present,
  input wire logic sleep_cond,
  input wire logic load_event,
  input wire logic hib_cond,
  // outputs to the gauge core and host
  output gcr_pmode_t power_mode,
  output logic locked,
  output logic host_temp_sel,
  output logic [15:0] host_temp,
  output logic [15:0] at_rate,
  output logic subcmd_stb,
  output logic [15:0] subcmd,
  output logic soc_int
);

  gcr_link_if lk ();

  logic [7:0] ptr, next_ptr;
  logic [7:0] wr_lo, next_wr_lo;
  logic [15:0] operation_config, next_operation_config;
  logic [15:0] next_host_temp, next_at_rate, next_subcmd;
  logic next_subcmd_stb, next_locked, key_armed, next_key_armed;
  logic hib_req, next_hib_req, snooze, next_snooze;
  gcr_pmode_t next_power_mode;
  logic [7:0] rd_byte, next_rd_byte;
  logic [15:0] soc_cnt, next_soc_cnt, soc_prev;
  logic next_soc_int;
  logic [7:0] mfg [FLASH_BYTES];
  logic [7:0] next_mfg [FLASH_BYTES];
  logic [4:0] widx;
  logic in_words, in_flash, idx_mapped, idx_writable;
  logic [15:0] wval, wnew, ctrl_word;

  // ------------------------------------------------------------------
  // serial target engine
  // ------------------------------------------------------------------
  gcr_i2c_target u_target (
    .clk(clk),
    .rst(rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .lk(lk.engine)
  );

  // R3 hibernate does not answer; every other mode does
  assign lk.accept = (power_mode != PM_HIBERNATE);
  assign lk.rd_data = rd_byte;

  // ------------------------------------------------------------------
  // address decode of the current pointer
  // ------------------------------------------------------------------
  // R1 one word per code pair, word index is code / 2
  assign widx = ptr[5:1];
  assign in_words = (ptr[7:6] == 2'h0);
  // R8 flash block page mapped directly at codes 0x40..0x5f
  assign in_flash = (ptr[7:5] == FLASH_PAGE);
  assign wnew = {lk.wr_data, wr_lo};

  // which word indices carry a standard quantity
  always_comb begin
    idx_mapped = 1'b0;
    for (int i = 0; i < NUM_STD; i++) begin
      if (STD_CODES[i][5:1] == widx) begin
        idx_mapped = 1'b1;
      end
    end
  end

  // R4 write permission depends on the access mode
  always_comb begin
    if (widx == STD_CODES[IX_CONTROL][5:1]) begin
      idx_writable = 1'b1;
    end else if (widx == STD_CODES[IX_AT_RATE][5:1]) begin
      idx_writable = 1'b1;
    end else if (widx == STD_CODES[IX_TEMPERATURE][5:1]) begin
      idx_writable = 1'b1;
    end else if (widx == STD_CODES[IX_OPERATION_CONFIG][5:1]) begin
      idx_writable = ~locked;
    end else begin
      idx_writable = 1'b0;
    end
  end

  // control word read back: status or identity by last subcommand
  always_comb begin
    ctrl_word = WORD_RESET;
    if (subcmd == SUB_DEV_TYPE) begin
      ctrl_word = DEV_TYPE_CODE;
    end else if (subcmd == SUB_FW_VER) begin
      ctrl_word = FW_VER_CODE;
    end else begin
      ctrl_word[STS_LOCKED] = locked;
      ctrl_word[STS_HIB] = hib_req;
      ctrl_word[STS_SNOOZE] = snooze;
      ctrl_word[STS_SLEEP] = (power_mode == PM_SLEEP);
    end
  end

  // read value of the addressed word
  always_comb begin
    if (widx == STD_CODES[IX_CONTROL][5:1]) begin
      wval = ctrl_word;
    end else if (widx == STD_CODES[IX_AT_RATE][5:1]) begin
      wval = at_rate;
    end else if (widx == STD_CODES[IX_TEMPERATURE][5:1]) begin
      // R7 host supplied temperature in tenths of a kelvin
      wval = host_temp_sel ? host_temp : core_word[widx];
    end else if (widx == STD_CODES[IX_OPERATION_CONFIG][5:1]) begin
      wval = operation_config;
    end else if (idx_mapped) begin
      wval = core_word[widx];
    end else begin
      wval = WORD_RESET;
    end
  end

  // ------------------------------------------------------------------
  // register map, access mode and power mode next state
  // ------------------------------------------------------------------
  always_comb begin
    next_ptr = ptr;
    next_wr_lo = wr_lo;
    next_operation_config = operation_config;
    next_host_temp = host_temp;
    next_at_rate = at_rate;
    next_subcmd = subcmd;
    next_subcmd_stb = 1'b0;
    next_locked = locked;
    next_key_armed = key_armed;
    next_hib_req = hib_req;
    next_snooze = snooze;
    next_mfg = mfg;
    next_power_mode = power_mode;
    if (lk.wr_valid) begin
      if (lk.wr_first) begin
        // R2 first byte of a write selects the command code
        next_ptr = lk.wr_data;
      end else begin
        next_ptr = ptr + 8'h01;
        if (in_flash) begin
          // R10 flash block refused while locked
          if (!locked) begin
            // R9 user block byte store
            next_mfg[ptr[4:0]] = lk.wr_data;
          end
        end else if (in_words && !ptr[0]) begin
          // R14 low byte held until the odd code arrives
          next_wr_lo = lk.wr_data;
        end else if (in_words && idx_writable) begin
          if (widx == STD_CODES[IX_CONTROL][5:1]) begin
            // R13 subcommand handed on with a strobe
            next_subcmd = wnew;
            next_subcmd_stb = 1'b1;
            next_key_armed = (wnew == OPEN_KEY1);
            if (locked && key_armed && wnew == OPEN_KEY2) begin
              next_locked = 1'b0;
            end
            case (wnew)
              // R6 host requested power mode changes, and SUB_LOCK sets the lock
              SUB_SET_HIB: next_hib_req = 1'b1;
              SUB_CLR_HIB: next_hib_req = 1'b0;
              SUB_SET_SNOOZE: next_snooze = 1'b1;
              SUB_CLR_SNOOZE: next_snooze = 1'b0;
              SUB_LOCK: next_locked = 1'b1;
              default: next_locked = next_locked;
            endcase
          end else if (widx == STD_CODES[IX_AT_RATE][5:1]) begin
            next_at_rate = wnew;
          end else if (widx == STD_CODES[IX_TEMPERATURE][5:1]) begin
            // R7 host writes the temperature word
            next_host_temp = wnew;
          end else begin
            next_operation_config = wnew;
          end
        end
      end
    end else if (lk.rd_next) begin
      // R14 sequential reads walk low byte then high byte
      next_ptr = ptr + 8'h01;
    end

    // R6 automatic mode changes on gauge events
    case (power_mode)
      PM_INSERT_CHECK: begin
        if (batt_present) begin
          next_power_mode = PM_NORMAL;
        end
      end
      PM_NORMAL: begin
        if (!batt_present) begin
          next_power_mode = PM_INSERT_CHECK;
        end else if (sleep_cond) begin
          next_power_mode = snooze ? PM_ENH_SLEEP : PM_SLEEP;
        end
      end
      PM_ENH_SLEEP: begin
        if (!sleep_cond || load_event || !snooze) begin
          next_power_mode = PM_NORMAL;
        end
      end
      PM_SLEEP: begin
        if (!sleep_cond || load_event) begin
          next_power_mode = PM_NORMAL;
        end else if (hib_req && hib_cond) begin
          next_power_mode = PM_HIBERNATE;
        end
      end
      PM_HIBERNATE: begin
        if (lk.addr_seen || load_event) begin
          next_power_mode = PM_NORMAL;
          next_hib_req = 1'b0;
        end
      end
      default: next_power_mode = PM_INSERT_CHECK;
    endcase
  end

  // read byte prepared ahead of every transmit slot
  always_comb begin
    if (in_flash) begin
      // R10 locked reads of the flash block show zero
      next_rd_byte = locked ? 8'h00 : mfg[ptr[4:0]];
    end else if (in_words) begin
      // R14 even code gives low byte, odd code high byte
      next_rd_byte = ptr[0] ? wval[15:8] : wval[7:0];
    end else begin
      next_rd_byte = 8'h00;
    end
  end

  // R11 charge-level change stretches the interrupt pulse
  always_comb begin
    next_soc_cnt = soc_cnt;
    if (core_word[STD_CODES[IX_CHARGE][5:1]] != soc_prev) begin
      next_soc_cnt = SOC_INT_CYCLES;
    end else if (soc_cnt != 16'h0000) begin
      next_soc_cnt = soc_cnt - 16'h0001;
    end
    next_soc_int = (next_soc_cnt != 16'h0000);
  end

  // ------------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr <= 8'h00;
      wr_lo <= 8'h00;
      operation_config <= OPERATION_CONFIG_RESET;
      host_temp <= WORD_RESET;
      at_rate <= WORD_RESET;
      subcmd <= SUB_STATUS;
      subcmd_stb <= 1'b0;
      locked <= LOCKED_RESET;
      key_armed <= 1'b0;
      hib_req <= 1'b0;
      snooze <= 1'b0;
      power_mode <= PM_INSERT_CHECK;
      rd_byte <= 8'h00;
      soc_cnt <= 16'h0000;
      soc_prev <= WORD_RESET;
      soc_int <= 1'b0;
      for (int i = 0; i < FLASH_BYTES; i++) begin
        mfg[i] <= 8'h00;
      end
    end else begin
      ptr <= next_ptr;
      wr_lo <= next_wr_lo;
      operation_config <= next_operation_config;
      host_temp <= next_host_temp;
      at_rate <= next_at_rate;
      subcmd <= next_subcmd;
      subcmd_stb <= next_subcmd_stb;
      locked <= next_locked;
      key_armed <= next_key_armed;
      hib_req <= next_hib_req;
      snooze <= next_snooze;
      power_mode <= next_power_mode;
      rd_byte <= next_rd_byte;
      soc_cnt <= next_soc_cnt;
      soc_prev <= core_word[STD_CODES[IX_CHARGE][5:1]];
      soc_int <= next_soc_int;
      mfg <= next_mfg;
    end
  end

  // R7 host temperature chosen by configuration
  assign host_temp_sel = operation_config[CFG_HOST_TEMP];

endmodule : gcr_command_map

// file: dv/gcr_command_map_assertions.sv
// concurrent checks on the command map top ports
`timescale 1ns/10ps
module gcr_command_map_checker
  import gcr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // core side
  input wire logic [NUM_WORDS-1:0][15:0] core_word,
  input wire logic batt_present,
  input wire logic sleep_cond,
  input wire logic load_event,
  input wire logic hib_cond,
  // outputs
  input wire gcr_pmode_t power_mode,
  input wire logic locked,
  input wire logic host_temp_sel,
  input wire logic [15:0] host_temp,
  input wire logic [15:0] at_rate,
  input wire logic subcmd_stb,
  input wire logic [15:0] subcmd,
  input wire logic soc_int
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // back in normal mode within two cycles
  sequence to_normal_s;
    ##[1:2] power_mode == PM_NORMAL;
  endsequence
  // ------
  // port checks
  // ------
  // target only pulls low, sda moves only while scl is low
  open_drain_a: assert property (!sda_o
    && (!$changed(sda_oe) || !scl_i)) else $error("sda moved with scl high");
  stb_pulse_a: assert property (subcmd_stb |=> !subcmd_stb)
    else $error("strobe too long");
  subcmd_hold_a: assert property (!subcmd_stb |-> $stable(subcmd))
    else $error("subcommand changed alone");
  soc_rise_a: assert property ($changed(core_word[22]) |-> ##[1:3] soc_int)
    else $error("no charge interrupt");
  soc_hold_a: assert property ($rose(soc_int) |=> soc_int[*8])
    else $error("interrupt too short");
  insert_exit_a: assert property (power_mode == PM_INSERT_CHECK
    && batt_present |-> to_normal_s) else $error("no exit to normal");
  sleep_entry_a: assert property (power_mode == PM_NORMAL && sleep_cond
    && batt_present |-> ##[1:2] power_mode inside {PM_ENH_SLEEP, PM_SLEEP})
    else $error("no sleep entry");
  sleep_wake_a: assert property (power_mode == PM_SLEEP
    && load_event |-> to_normal_s) else $error("no wake on load");
  lock_set_a: assert property (subcmd_stb && subcmd == SUB_LOCK
    |-> ##[0:1] locked) else $error("lock not taken");
endmodule : gcr_command_map_checker

// file: dv/gcr_host_model.sv
// bus host model: start, stop, byte and word transfers
`timescale 1ns/10ps
module gcr_host_model
  import gcr_pkg::*;
#(
  parameter int Q = 8,
  parameter int BUF = 100
) (
  // clock
  input wire logic clk,
  // bus wires
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // set both lines then hold a quarter bit
  task automatic pin(input logic s, input logic d);
    scl <= s;
    sda_low <= d;
    repeat (Q) @(posedge clk);
  endtask : pin
  task automatic start();
    pin(scl, 1'b0);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b1);
    pin(1'b0, 1'b1);
  endtask : start
  task automatic stop();
    pin(1'b0, 1'b1);
    pin(1'b1, 1'b1);
    pin(1'b1, 1'b0);
    repeat (BUF) @(posedge clk);
  endtask : stop
  // one bit, sampled mid high
  task automatic bitx(input logic b, output logic r);
    pin(1'b0, !b);
    pin(1'b1, !b);
    r = sda;
    pin(1'b1, !b);
    pin(1'b0, !b);
  endtask : bitx
  // eight bits then the acknowledge bit
  task automatic byte_x(input logic [7:0] w, input logic nk,
                        output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
    bitx(nk, a);
    ack = !a;
  endtask : byte_x
  // code transfer, then low and high data bytes
  task automatic wr(input logic [6:0] a, input logic [7:0] c,
                    input logic [15:0] d, output logic ok);
    logic [7:0] r;
    logic k0, k1, k2, k3;
    start();
    byte_x({a, 1'b0}, 1'b1, r, k0);
    byte_x(c, 1'b1, r, k1);
    byte_x(d[7:0], 1'b1, r, k2);
    byte_x(d[15:8], 1'b1, r, k3);
    stop();
    ok = k0 & k1 & k2 & k3;
  endtask : wr
  // code transfer, repeated start, two data bytes
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    logic [7:0] r;
    logic k;
    start();
    byte_x({DEV_ADDR, 1'b0}, 1'b1, r, k);
    byte_x(c, 1'b1, r, k);
    start();
    byte_x({DEV_ADDR, 1'b1}, 1'b1, r, k);
    byte_x(8'hff, 1'b0, d[7:0], k);
    byte_x(8'hff, 1'b1, d[15:8], k);
    stop();
  endtask : rd
endmodule : gcr_host_model

// file: dv/tb.sv
// top testbench of the command map
`timescale 1ns/10ps
module tb
  import gcr_pkg::*;
;
  logic clk, rst, scl, sda_low, sda, sda_o, sda_oe, ok;
  logic batt_present, sleep_cond, load_event, hib_cond;
  logic [NUM_WORDS-1:0][15:0] core_word;
  gcr_pmode_t power_mode;
  logic locked, host_temp_sel, subcmd_stb, soc_int;
  logic [15:0] host_temp, at_rate, subcmd, d;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  // open drain line with pull-up
  assign sda = (sda_low || sda_oe) ? 1'b0 : 1'b1;
  gcr_command_map dut_u (
    .clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .core_word(core_word), .batt_present(batt_present),
    .sleep_cond(sleep_cond), .load_event(load_event), .hib_cond(hib_cond),
    .power_mode(power_mode), .locked(locked), .host_temp(host_temp),
    .host_temp_sel(host_temp_sel), .at_rate(at_rate), .subcmd(subcmd),
    .subcmd_stb(subcmd_stb), .soc_int(soc_int));
  gcr_host_model #(.Q(8), .BUF(100)) host_u (
    .clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      finish_test();
    end
  end
  // main sequence
  initial begin
    rst = 1'b1;
    batt_present = 1'b0;
    sleep_cond = 1'b0;
    load_event = 1'b0;
    hib_cond = 1'b0;
    core_word = '0;
    core_word[4] = 16'hbeef;
    core_word[22] = 16'h0032;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    batt_present <= 1'b1;
    repeat (4) @(posedge clk);
    chk(16'(power_mode), 16'(PM_NORMAL));
    host_u.wr(DEV_ADDR, 8'h02, 16'h1234, ok);
    chk(at_rate, 16'h1234);
    host_u.rd(8'h02, d);
    chk(d, 16'h1234);
    host_u.wr(DEV_ADDR, 8'h08, 16'h0000, ok);
    host_u.rd(8'h08, d);
    chk(d, 16'hbeef);
    host_u.wr(7'h56, 8'h02, 16'h0000, ok);
    chk(16'(ok), 16'h0000);
    core_word[22] <= 16'h0033;
    repeat (4) @(posedge clk);
    chk(16'(soc_int), 16'h0001);
    host_u.rd(8'h2c, d);
    chk(d, 16'h0033);
    host_u.wr(DEV_ADDR, 8'h00, 16'h0013, ok);
    chk(subcmd, 16'h0013);
    host_u.rd(8'h00, d);
    chk(d & 16'h0020, 16'h0020);
    sleep_cond <= 1'b1;
    repeat (4) @(posedge clk);
    chk(16'(power_mode), 16'(PM_ENH_SLEEP));
    sleep_cond <= 1'b0;
    host_u.wr(DEV_ADDR, 8'h00, 16'h0014, ok);
    sleep_cond <= 1'b1;
    repeat (4) @(posedge clk);
    chk(16'(power_mode), 16'(PM_SLEEP));
    sleep_cond <= 1'b0;
    load_event <= 1'b1;
    @(posedge clk);
    load_event <= 1'b0;
    repeat (2) @(posedge clk);
    chk(16'(power_mode), 16'(PM_NORMAL));
    host_u.wr(DEV_ADDR, 8'h00, SUB_SET_HIB, ok);
    sleep_cond <= 1'b1;
    hib_cond <= 1'b1;
    repeat (4) @(posedge clk);
    chk(16'(power_mode), 16'(PM_HIBERNATE));
    sleep_cond <= 1'b0;
    host_u.wr(DEV_ADDR, 8'h02, 16'h0000, ok);
    chk(16'(ok), 16'h0000);
    chk(16'(power_mode), 16'(PM_NORMAL));
    host_u.wr(DEV_ADDR, 8'h00, 16'h0001, ok);
    host_u.rd(8'h00, d);
    chk(d, DEV_TYPE_CODE);
    host_u.wr(DEV_ADDR, 8'h3a, 16'h0001, ok);
    host_u.wr(DEV_ADDR, 8'h06, 16'h0bb8, ok);
    host_u.rd(8'h06, d);
    chk(d, 16'h0bb8);
    host_u.wr(DEV_ADDR, 8'h40, 16'ha55a, ok);
    host_u.rd(8'h40, d);
    chk(d, 16'ha55a);
    host_u.wr(DEV_ADDR, 8'h00, 16'h0020, ok);
    chk(16'(locked), 16'h0001);
    host_u.wr(DEV_ADDR, 8'h06, 16'h0c1c, ok);
    chk(host_temp, 16'h0c1c);
    host_u.wr(DEV_ADDR, 8'h3a, 16'h0000, ok);
    chk(16'(host_temp_sel), 16'h0001);
    host_u.rd(8'h40, d);
    chk(d, 16'h0000);
    host_u.rd(8'h00, d);
    chk(d & 16'h2000, 16'h2000);
    host_u.wr(DEV_ADDR, 8'h00, OPEN_KEY1, ok);
    host_u.wr(DEV_ADDR, 8'h00, OPEN_KEY2, ok);
    chk(16'(locked), 16'h0000);
    finish_test();
  end
endmodule : tb
bind gcr_command_map gcr_command_map_checker chk_u (
  .clk(clk), .rst(rst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .core_word(core_word), .batt_present(batt_present),
  .sleep_cond(sleep_cond), .load_event(load_event), .hib_cond(hib_cond),
  .power_mode(power_mode), .locked(locked), .host_temp(host_temp),
  .host_temp_sel(host_temp_sel), .at_rate(at_rate), .subcmd(subcmd),
  .subcmd_stb(subcmd_stb), .soc_int(soc_int));
